// ---- logic/pcx_route_defs.vh ----
`ifndef PCX_ROUTE_DEFS_VH
`define PCX_ROUTE_DEFS_VH

// ----------------------------------------------------------------
// register reset values and writable masks
// ----------------------------------------------------------------
`define PCX_SEL_A_RESET       8'h00
`define PCX_SEL_B_RESET       8'h00
`define PCX_SEL_A_WR_MASK     8'hFF
`define PCX_SEL_B_WR_MASK     8'hDC

// ----------------------------------------------------------------
// crossbar_route_select_a fields
// ----------------------------------------------------------------
`define PCX_A_INVERTED_SYSTEM_CLOCK_BIT      7
`define PCX_A_T2_TRIG_BIT     6
`define PCX_A_T2_COUNT_BIT    5
`define PCX_A_IRQ1_BIT        4
`define PCX_A_T1_COUNT_BIT    3
`define PCX_A_IRQ0_BIT        2
`define PCX_A_T0_COUNT_BIT    1
`define PCX_A_CMP1_BIT        0

// ----------------------------------------------------------------
// crossbar_route_select_b fields
// ----------------------------------------------------------------
`define PCX_B_PULLUP_DIS_BIT  7
`define PCX_B_MASTER_EN_BIT   6
`define PCX_B_T4_TRIG_BIT     4
`define PCX_B_T4_COUNT_BIT    3
`define PCX_B_UART2_BIT       2

// ----------------------------------------------------------------
// signal slots, listed in pin-claim priority order
// ----------------------------------------------------------------
`define PCX_NUM_SLOTS         12
`define PCX_SLOT_CMP1         4'h0
`define PCX_SLOT_T0_COUNT     4'h1
`define PCX_SLOT_IRQ0         4'h2
`define PCX_SLOT_T1_COUNT     4'h3
`define PCX_SLOT_IRQ1         4'h4
`define PCX_SLOT_T2_COUNT     4'h5
`define PCX_SLOT_T2_TRIG      4'h6
`define PCX_SLOT_T4_COUNT     4'h7
`define PCX_SLOT_T4_TRIG      4'h8
`define PCX_SLOT_UART2_TX     4'h9
`define PCX_SLOT_UART2_RX     4'hA
`define PCX_SLOT_INVERTED_SYSTEM_CLOCK       4'hB
`define PCX_SLOT_NONE         4'hF

`endif

// ---- logic/pcx_route_ctrl.v ----
// Overview of operation
// R1 - inverted system clock reaches a pin only while its enable bit is set.
// R2 - external interrupt one input gets a pin only while its enable is set.
// R3 - timer one count input gets a pin only while its enable is set.
// R4 - timer zero count input gets a pin only while its enable is set.
// R5 - pull-up disable bit clear enables weak pull-ups; set disables them all.
// R6 - routing selections take effect only while master crossbar enable is set.
// R7 - master enable clear forces all crossbar pins to input, drivers off.
// R8 - enabled signals take pins in fixed priority, skipping analog-input pins.
// R9 - remaining enable bits claim pins in priority order only when set.
`include "pcx_route_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module pcx_route_ctrl #(
  parameter NUM_PINS = 32
) (
  // clock and reset
  input  wire                clock,
  input  wire                sys_rst,
  // register writes
  input  wire                selAWrEn,
  input  wire                selBWrEn,
  input  wire [7:0]          selWrData,
  // register read-back
  output reg  [7:0]          crossbarRouteSelectA_r,
  output reg  [7:0]          crossbarRouteSelectB_r,
  // pin skip mask: analog inputs and pins held by higher-priority peripherals
  input  wire [NUM_PINS-1:0] skipPins,
  // peripheral outputs to be routed
  input  wire                invertedSystemClock,
  input  wire                cmpOneOut,
  input  wire                uartTwoTx,
  // general purpose drive for unassigned pins
  input  wire [NUM_PINS-1:0] gpioOut,
  input  wire [NUM_PINS-1:0] gpioOutEn,
  // pins
  input  wire [NUM_PINS-1:0] pinIn,
  output reg  [NUM_PINS-1:0] pinOut_r,
  output reg  [NUM_PINS-1:0] pinOutEn_r,
  output reg                 pullUpEn_r,
  // routed peripheral inputs, idle high when not routed
  output reg                 timerZeroCountInput_r,
  output reg                 timerOneCountInput_r,
  output reg                 extIrqZeroInput_r,
  output reg                 extIrqOneInput_r,
  output reg                 timerTwoCountInput_r,
  output reg                 timerTwoTriggerInput_r,
  output reg                 timerFourCountInput_r,
  output reg                 timerFourTriggerInput_r,
  output reg                 uartTwoRx_r
);

  // ----------------------------------------------------------------
  // slot enables
  // ----------------------------------------------------------------
  wire                        masterEn = crossbarRouteSelectB_r[`PCX_B_MASTER_EN_BIT];
  wire [`PCX_NUM_SLOTS-1:0]   slotReq;
  wire [`PCX_NUM_SLOTS-1:0]   slotEn;

  // R1 inverted_system_clock enable
  assign slotReq[`PCX_SLOT_INVERTED_SYSTEM_CLOCK]   = crossbarRouteSelectA_r[`PCX_A_INVERTED_SYSTEM_CLOCK_BIT];
  // R2 irq one enable
  assign slotReq[`PCX_SLOT_IRQ1]     = crossbarRouteSelectA_r[`PCX_A_IRQ1_BIT];
  // R3 timer one enable
  assign slotReq[`PCX_SLOT_T1_COUNT] = crossbarRouteSelectA_r[`PCX_A_T1_COUNT_BIT];
  // R4 timer zero enable
  assign slotReq[`PCX_SLOT_T0_COUNT] = crossbarRouteSelectA_r[`PCX_A_T0_COUNT_BIT];
  // R9 remaining enables
  assign slotReq[`PCX_SLOT_CMP1]     = crossbarRouteSelectA_r[`PCX_A_CMP1_BIT];
  assign slotReq[`PCX_SLOT_IRQ0]     = crossbarRouteSelectA_r[`PCX_A_IRQ0_BIT];
  assign slotReq[`PCX_SLOT_T2_COUNT] = crossbarRouteSelectA_r[`PCX_A_T2_COUNT_BIT];
  assign slotReq[`PCX_SLOT_T2_TRIG]  = crossbarRouteSelectA_r[`PCX_A_T2_TRIG_BIT];
  assign slotReq[`PCX_SLOT_T4_COUNT] = crossbarRouteSelectB_r[`PCX_B_T4_COUNT_BIT];
  assign slotReq[`PCX_SLOT_T4_TRIG]  = crossbarRouteSelectB_r[`PCX_B_T4_TRIG_BIT];
  // one uart bit claims two slots, so tx and rx take consecutive free pins
  assign slotReq[`PCX_SLOT_UART2_TX] = crossbarRouteSelectB_r[`PCX_B_UART2_BIT];
  assign slotReq[`PCX_SLOT_UART2_RX] = crossbarRouteSelectB_r[`PCX_B_UART2_BIT];

  // clearing master enable drops every claim at once
  // R6 master gate
  assign slotEn = masterEn ? slotReq : {`PCX_NUM_SLOTS{1'b0}};

  // ----------------------------------------------------------------
  // priority pin assignment
  // ----------------------------------------------------------------
  // linear search per pin: simple, but logic depth grows with slots times pins
  function [3:0] nextSlot;
    input [`PCX_NUM_SLOTS-1:0] en;
    input [4:0]                from;
    integer                    j;
    reg                        found;
    begin
      // the none code doubles as the end-of-list marker
      nextSlot = `PCX_SLOT_NONE;
      found    = 1'b0;
      for (j = 0; j < `PCX_NUM_SLOTS; j = j + 1) begin
        if (!found && (j >= from) && en[j]) begin
          nextSlot = j[3:0];
          found    = 1'b1;
        end
      end
    end
  endfunction

  // one 4-bit slot code per pin; the none code marks a free pin
  reg [4*NUM_PINS-1:0]       pinSlot;
  reg [3:0]                  curSlot;
  reg [NUM_PINS-1:0]         pinOut_nxt;
  reg [NUM_PINS-1:0]         pinOutEn_nxt;
  reg [`PCX_NUM_SLOTS-1:0]   slotIn;
  reg [3:0]                  sl;
  integer                    p;
  integer                    q;

  // each placed slot restarts the search just past itself, so no slot takes two pins
  // R8 priority with skip
  always @* begin
    pinSlot = {NUM_PINS{`PCX_SLOT_NONE}};
    curSlot = nextSlot(slotEn, 5'h00);
    for (p = 0; p < NUM_PINS; p = p + 1) begin
      if (!skipPins[p] && (curSlot < `PCX_NUM_SLOTS)) begin
        pinSlot[4*p +: 4] = curSlot;
        curSlot           = nextSlot(slotEn, {1'b0, curSlot} + 5'h01);
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive and input routing
  // ----------------------------------------------------------------
  always @* begin
    pinOut_nxt   = {NUM_PINS{1'b0}};
    pinOutEn_nxt = {NUM_PINS{1'b0}};
    // unclaimed inputs rest high
    slotIn       = {`PCX_NUM_SLOTS{1'b1}};
    sl           = `PCX_SLOT_NONE;
    for (q = 0; q < NUM_PINS; q = q + 1) begin
      sl = pinSlot[4*q +: 4];
      case (sl)
        // R1 inverted_system_clock drive
        `PCX_SLOT_INVERTED_SYSTEM_CLOCK: begin
          pinOut_nxt[q]   = invertedSystemClock;
          pinOutEn_nxt[q] = 1'b1;
        end
        // R9 comparator drive
        `PCX_SLOT_CMP1: begin
          pinOut_nxt[q]   = cmpOneOut;
          pinOutEn_nxt[q] = 1'b1;
        end
        // R9 uart transmit drive
        `PCX_SLOT_UART2_TX: begin
          pinOut_nxt[q]   = uartTwoTx;
          pinOutEn_nxt[q] = 1'b1;
        end
        // free pins fall back to general purpose drive
        `PCX_SLOT_NONE: begin
          pinOut_nxt[q]   = gpioOut[q];
          pinOutEn_nxt[q] = gpioOutEn[q];
        end
        // input slots read their pin and leave its driver off
        default: begin
          slotIn[sl] = pinIn[q];
        end
      endcase
    end
    // R7 drivers off when disabled
    if (!masterEn) begin
      pinOutEn_nxt = {NUM_PINS{1'b0}};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      crossbarRouteSelectA_r  <= `PCX_SEL_A_RESET;
      crossbarRouteSelectB_r  <= `PCX_SEL_B_RESET;
      pinOut_r                <= {NUM_PINS{1'b0}};
      pinOutEn_r              <= {NUM_PINS{1'b0}};
      pullUpEn_r              <= 1'b1;
      // unrouted inputs rest high, the idle level of the active-low interrupts
      timerZeroCountInput_r   <= 1'b1;
      timerOneCountInput_r    <= 1'b1;
      extIrqZeroInput_r       <= 1'b1;
      extIrqOneInput_r        <= 1'b1;
      timerTwoCountInput_r    <= 1'b1;
      timerTwoTriggerInput_r  <= 1'b1;
      timerFourCountInput_r   <= 1'b1;
      timerFourTriggerInput_r <= 1'b1;
      uartTwoRx_r             <= 1'b1;
    end else begin
      if (selAWrEn) begin
        crossbarRouteSelectA_r <= selWrData & `PCX_SEL_A_WR_MASK;
      end
      // unused and reserved bits stay zero
      if (selBWrEn) begin
        crossbarRouteSelectB_r <= selWrData & `PCX_SEL_B_WR_MASK;
      end
      // pin drive is registered so every output leaves a flip-flop
      pinOut_r                <= pinOut_nxt;
      pinOutEn_r              <= pinOutEn_nxt;
      // R5 global pull-ups
      pullUpEn_r              <= ~crossbarRouteSelectB_r[`PCX_B_PULLUP_DIS_BIT];
      // R4 timer zero input
      timerZeroCountInput_r   <= slotIn[`PCX_SLOT_T0_COUNT];
      // R3 timer one input
      timerOneCountInput_r    <= slotIn[`PCX_SLOT_T1_COUNT];
      extIrqZeroInput_r       <= slotIn[`PCX_SLOT_IRQ0];
      // R2 irq one input
      extIrqOneInput_r        <= slotIn[`PCX_SLOT_IRQ1];
      // R9 remaining inputs
      timerTwoCountInput_r    <= slotIn[`PCX_SLOT_T2_COUNT];
      timerTwoTriggerInput_r  <= slotIn[`PCX_SLOT_T2_TRIG];
      timerFourCountInput_r   <= slotIn[`PCX_SLOT_T4_COUNT];
      timerFourTriggerInput_r <= slotIn[`PCX_SLOT_T4_TRIG];
      uartTwoRx_r             <= slotIn[`PCX_SLOT_UART2_RX];
    end
  end

endmodule // pcx_route_ctrl

`default_nettype wire

// ---- bench/pcx_route_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// routing checker
// ----
module pcx_route_checker #(
  parameter NUM_PINS = 32
) (
  input wire logic                clock,
  input wire logic                sys_rst,
  input wire logic                selAWrEn,
  input wire logic                selBWrEn,
  input wire logic [7:0]          selWrData,
  input wire logic [7:0]          crossbarRouteSelectA_r,
  input wire logic [7:0]          crossbarRouteSelectB_r,
  input wire logic [NUM_PINS-1:0] skipPins,
  input wire logic                invertedSystemClock,
  input wire logic                cmpOneOut,
  input wire logic [NUM_PINS-1:0] pinIn,
  input wire logic [NUM_PINS-1:0] pinOut_r,
  input wire logic [NUM_PINS-1:0] pinOutEn_r,
  input wire logic                pullUpEn_r,
  input wire logic                timerZeroCountInput_r,
  input wire logic                timerOneCountInput_r,
  input wire logic                extIrqOneInput_r,
  input wire logic                uartTwoRx_r
);
  wire logic [7:0] a = crossbarRouteSelectA_r;
  wire logic [7:0] b = crossbarRouteSelectB_r;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  chk_reg_a_write:
    assert property (selAWrEn |=> a == $past(selWrData)) else $error("reg a write lost");
  chk_reg_b_mask:
    assert property (selBWrEn |=> b == ($past(selWrData) & 8'hDC)) else $error("reg b write wrong");
  chk_master_off_quiet:
    assert property (!b[6] |=> pinOutEn_r == '0 && timerZeroCountInput_r && uartTwoRx_r)
      else $error("pins active with crossbar off");
  chk_pullup_follow:
    assert property (##1 pullUpEn_r != $past(b[7])) else $error("pull-up state wrong");
  chk_irq_one_idle:
    assert property (!a[4] |=> extIrqOneInput_r) else $error("irq one routed while off");
  chk_t1_idle:
    assert property (!a[3] |=> timerOneCountInput_r) else $error("timer one routed while off");
  chk_t0_first_pin:
    assert property (a == 8'h02 && b[6] && skipPins == '0 |=> timerZeroCountInput_r == $past(pinIn[0]))
      else $error("timer zero not on pin 0");
  chk_inverted_system_clock_pin:
    assert property (a == 8'h80 && b[6] && skipPins == '0 |=> pinOutEn_r[0] && pinOut_r[0] == $past(invertedSystemClock))
      else $error("clock output not on pin 0");
  chk_skip_order:
    assert property (a == 8'h01 && b[6] && skipPins[1:0] == 2'b01 |=> pinOutEn_r[1] && pinOut_r[1] == $past(cmpOneOut))
      else $error("skipped pin not passed over");
endmodule // pcx_route_checker

bind pcx_route_ctrl pcx_route_checker #(.NUM_PINS(NUM_PINS)) chk (.clock(clock), .sys_rst(sys_rst),
  .selAWrEn(selAWrEn), .selBWrEn(selBWrEn), .selWrData(selWrData), .crossbarRouteSelectA_r(crossbarRouteSelectA_r),
  .crossbarRouteSelectB_r(crossbarRouteSelectB_r), .skipPins(skipPins), .invertedSystemClock(invertedSystemClock),
  .cmpOneOut(cmpOneOut), .pinIn(pinIn), .pinOut_r(pinOut_r), .pinOutEn_r(pinOutEn_r), .pullUpEn_r(pullUpEn_r),
  .timerZeroCountInput_r(timerZeroCountInput_r), .timerOneCountInput_r(timerOneCountInput_r),
  .extIrqOneInput_r(extIrqOneInput_r), .uartTwoRx_r(uartTwoRx_r));
`default_nettype wire

// ---- bench/pcx_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// pins and peripherals
// ----
module pcx_pin_model #(
  parameter NUM_PINS = 8
) (
  input  wire logic                clock,
  input  wire logic [NUM_PINS-1:0] pinOut,
  input  wire logic [NUM_PINS-1:0] pinOutEn,
  input  wire logic                pullUpEn,
  input  wire logic [NUM_PINS-1:0] extEn,
  input  wire logic [NUM_PINS-1:0] extLvl,
  output logic      [NUM_PINS-1:0] pinIn,
  output logic                     invSysClk,
  output logic                     cmpOut,
  output logic                     uartTx
);
  logic [3:0] cnt = 4'h0;
  always @(posedge clock) cnt <= cnt + 4'h1;
  assign invSysClk = ~cnt[0];
  assign cmpOut = cnt[1];
  assign uartTx = cnt[2];
  // weak pull-ups hold a floating pin high; with them off it toggles so it never reads a steady guess
  assign pinIn = (pinOutEn & pinOut) | (~pinOutEn & extEn & extLvl) | (~pinOutEn & ~extEn & {NUM_PINS{pullUpEn | cnt[0]}});
endmodule // pcx_pin_model
`default_nettype wire

// ---- bench/pcx_route_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcx_route_ctrl_tb_top;
  logic       clock, sys_rst, selAWrEn, selBWrEn, pullUpEn, invClk, cmpOut, uTx, p;
  logic       t0, t1, i0, i1, t2, t2x, t4, t4x, uRx;
  logic [7:0] selWrData, regA, regB, skipPins, gpioOut, gpioOutEn, pinIn, pinOut, pinOutEn, extEn, extLvl;
  int         n_mismatch = 0;
  int         n_checks = 0;
  pcx_route_ctrl #(.NUM_PINS(8)) uut (.clock(clock), .sys_rst(sys_rst), .selAWrEn(selAWrEn), .selBWrEn(selBWrEn),
    .selWrData(selWrData), .crossbarRouteSelectA_r(regA), .crossbarRouteSelectB_r(regB), .skipPins(skipPins),
    .invertedSystemClock(invClk), .cmpOneOut(cmpOut), .uartTwoTx(uTx), .gpioOut(gpioOut), .gpioOutEn(gpioOutEn),
    .pinIn(pinIn), .pinOut_r(pinOut), .pinOutEn_r(pinOutEn), .pullUpEn_r(pullUpEn), .timerZeroCountInput_r(t0),
    .timerOneCountInput_r(t1), .extIrqZeroInput_r(i0), .extIrqOneInput_r(i1), .timerTwoCountInput_r(t2),
    .timerTwoTriggerInput_r(t2x), .timerFourCountInput_r(t4), .timerFourTriggerInput_r(t4x), .uartTwoRx_r(uRx));
  pcx_pin_model #(.NUM_PINS(8)) pins (.clock(clock), .pinOut(pinOut), .pinOutEn(pinOutEn), .pullUpEn(pullUpEn),
    .extEn(extEn), .extLvl(extLvl), .pinIn(pinIn), .invSysClk(invClk), .cmpOut(cmpOut), .uartTx(uTx));
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // strobes stay up between calls so back-to-back writes never reassign them in one step
  task automatic wr(input logic selB, input logic [7:0] d);
    selAWrEn = !selB;
    selBWrEn = selB;
    selWrData = d;
    @(posedge clock) #1;
  endtask
  task automatic settle();
    selAWrEn = 0;
    selBWrEn = 0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_regs();
    check("reset regs", 16'h0000, {regA, regB});
    check("reset idle", 16'h03FF, {pullUpEn, t0, t1, i0, i1, t2, t2x, t4, t4x, uRx});
    wr(1, 8'hFF);
    wr(0, 8'hFF);
    settle();
    check("reg b", 16'h00DC, regB);
    check("reg a", 16'h00FF, regA);
    check("pull-up off", 16'h0000, pullUpEn);
    extEn = 8'hFF;
    gpioOut = 8'hA5;
    gpioOutEn = 8'hFF;
    wr(1, 8'h80);
    settle();
    check("forced input", 16'h0000, pinOutEn);
    check("routed idle", 16'h01FF, {t0, t1, i0, i1, t2, t2x, t4, t4x, uRx});
    $display("test regs done");
  endtask
  task automatic t_route();
    skipPins = 8'h01;
    extEn = 8'h06;
    extLvl = 8'h02;
    wr(0, 8'h14);
    wr(1, 8'h40);
    settle();
    check("irq pair", 16'h0002, {i0, i1});
    check("pull-up on", 16'h0001, pullUpEn);
    extLvl = 8'h00;
    wr(0, 8'h04);
    settle();
    check("irq one off", 16'h0001, {i0, i1});
    skipPins = 8'h00;
    extEn = 8'h03;
    extLvl = 8'h02;
    wr(0, 8'h0A);
    settle();
    check("timers", 16'h0001, {t0, t1});
    extLvl = 8'h01;
    wr(0, 8'h02);
    settle();
    check("timer one off", 16'h0003, {t0, t1});
    $display("test route done");
  endtask
  task automatic t_outputs();
    extEn = 8'h02;
    extLvl = 8'h00;
    wr(0, 8'h80);
    settle();
    p = invClk;
    @(posedge clock) #1;
    check("clock pin", {14'h0, 2'b11}, {pinOutEn[0], pinOut[0] ^ p ^ 1'b1});
    skipPins = 8'h01;
    wr(0, 8'h01);
    settle();
    p = cmpOut;
    @(posedge clock) #1;
    check("cmp pin", 16'h0003, {pinOutEn[1], pinOut[1] ^ p ^ 1'b1});
    skipPins = 8'h00;
    wr(0, 8'h00);
    wr(1, 8'h44);
    settle();
    p = uTx;
    @(posedge clock) #1;
    check("uart tx", 16'h0007, {pinOutEn[1:0] ^ 2'b10, pinOut[0] ^ p ^ 1'b1});
    check("uart rx low", 16'h0000, uRx);
    extLvl = 8'h02;
    repeat (2) @(posedge clock);
    #1;
    check("uart rx high", 16'h0001, uRx);
    check("free pins", 16'hFCA4, {pinOutEn & 8'hFC, pinOut & 8'hFC});
    $display("test outputs done");
  endtask
  task automatic t_timers();
    skipPins = 8'h05;
    extEn = 8'hFF;
    extLvl = 8'h12;
    wr(0, 8'h60);
    wr(1, 8'h58);
    settle();
    check("timer two four", 16'h000A, {t2, t2x, t4, t4x});
    check("claimed pins", 16'h00C5, pinOutEn);
    sys_rst = 1;
    @(posedge clock) #1;
    sys_rst = 0;
    check("mid reset regs", 16'h0000, {regA, regB});
    check("mid reset pins", 16'h0000, pinOutEn);
    @(posedge clock) #1;
    check("mid reset idle", 16'h03FF, {pullUpEn, t0, t1, i0, i1, t2, t2x, t4, t4x, uRx});
    $display("test timers done");
  endtask
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // the tests need about 55 cycles; the 1000-cycle limit, about eighteen times that, marks a hang
  initial begin
    #10000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    {sys_rst, selAWrEn, selBWrEn, selWrData, skipPins} = {2'b10, 17'h0};
    {gpioOut, gpioOutEn, extEn, extLvl} = 32'h0;
    repeat (4) @(posedge clock);
    #1;
    sys_rst = 0;
    t_regs();
    t_route();
    t_outputs();
    t_timers();
    stop_test();
  end
endmodule // pcx_route_ctrl_tb_top
`default_nettype wire
